/* logic/sepv_pkg.sv */
// shared constants and state types for the serial program/verify link
package sepv_pkg;

    // ==========================================================
    // image layout
    localparam int IMAGE_BITS = 192;
    localparam int WORD_BITS = 16;
    localparam int NUM_WORDS = IMAGE_BITS / WORD_BITS;
    localparam int FRAME_BITS = 2 * WORD_BITS;
    localparam int ADDR_W = 4;
    localparam int CNT_W = 8;
    localparam int TIMER_W = 24;

    // ==========================================================
    // synchroniser bit positions in the device
    localparam int PIN_DATA = 0;
    localparam int PIN_B0 = 1;
    localparam int PIN_B1 = 2;
    localparam int PIN_B2 = 3;
    localparam int PIN_B3 = 4;
    localparam int PIN_SUPPLY = 5;
    localparam int PIN_W = 6;

    // ==========================================================
    // timing, printed figures then cycle counts at 250 MHz
    localparam real CLK_PERIOD_NS = 4.0;
    localparam real ENTRY_HOLD_MS = 9.0;
    localparam real ENTRY_SETUP_MS = 4.9;
    localparam real WRITE_DELAY_MS = 30.0;
    localparam real CLK_LOW_US = 25.0;
    localparam real CLK_HIGH_US = 25.0;
    localparam int ENTRY_HOLD_CYC = int'($ceil(ENTRY_HOLD_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int ENTRY_SETUP_CYC = int'($floor(ENTRY_SETUP_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int WRITE_DELAY_CYC = int'($floor(WRITE_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int CLK_LOW_CYC = int'($ceil(CLK_LOW_US * 1.0e3 / CLK_PERIOD_NS));
    localparam int CLK_HIGH_CYC = int'($ceil(CLK_HIGH_US * 1.0e3 / CLK_PERIOD_NS));
    // slack for both synchronisers on top of the full write delay
    localparam int ACK_MARGIN_CYC = 16;
    localparam int PRG_WAIT_CYC = int'($ceil(WRITE_DELAY_MS * 1.0e6 / CLK_PERIOD_NS)) + ACK_MARGIN_CYC;

    // ==========================================================
    // state types
    typedef enum logic [2:0] {
        DEV_IDLE, DEV_SETUP, DEV_SHIFT, DEV_WRITE, DEV_ACK, DEV_VERIFY, DEV_DONE
    } sepv_dev_state_e;

    typedef enum logic [3:0] {
        PRG_IDLE, PRG_HOLD, PRG_SETUP, PRG_BIT_LOW, PRG_BIT_HIGH, PRG_WAIT,
        PRG_ACK_HIGH, PRG_VER_LOW, PRG_VER_HIGH, PRG_OFF
    } sepv_prg_state_e;

endpackage

/* logic/sepv_if.sv */
// pins between the two ends, shared data line resolved
`timescale 1ns/10ps
`default_nettype none

interface sepv_if;
    logic supply_on;
    logic button_input_three;
    logic button_input_two;
    logic button_input_one;
    logic button_input_zero;
    logic prg_data;
    logic prg_data_oe;
    logic dev_data;
    logic dev_data_oe;
    logic data_line;

    // the line has a weak pull to ground when nobody drives it
    assign data_line = dev_data_oe ? dev_data : (prg_data_oe ? prg_data : 1'b0);

    modport dev (
        input supply_on, button_input_three, button_input_two,
        input button_input_one, button_input_zero, data_line,
        output dev_data, dev_data_oe
    );

    modport prg (
        output supply_on, button_input_three, button_input_two,
        output button_input_one, button_input_zero, prg_data, prg_data_oe,
        input data_line
    );
endinterface

`default_nettype wire

/* logic/sepv_device.sv */
// device end: entry detect, word shift-in, write with ack, one-shot verify
`timescale 1ns/10ps
`default_nettype none

// How it works
// - all 192 bits stored
// - long hold then data high enters
// - data rise soon after hold
// - buttons one and zero stay low
// - word then complement, button clock
// - write lasts at most the delay
// - ack bit after the write
// - first good word bulk-erases
// - verify clock shifts bits out
// - no read-back without programming
// - one verify pass only
// - unused buttons grounded
// - supply removal resets device
module sepv_device
    import sepv_pkg::*;
#(
    parameter int HOLD_CYC = ENTRY_HOLD_CYC,
    parameter int SETUP_CYC = ENTRY_SETUP_CYC,
    parameter int WRITE_CYC = WRITE_DELAY_CYC
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    sepv_if.dev link,
    input wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [WORD_BITS-1:0] rd_data_o,
    output logic prog_mode_o,
    output logic verify_mode_o,
    output logic done_o,
    output logic cmp_err_o
);

    // ==========================================================
    // pin synchronisers
    logic [PIN_W-1:0] pin_meta_q, pin_sync_q;
    logic clk_prev_q;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {link.supply_on, link.button_input_three, link.button_input_two,
                           link.button_input_one, link.button_input_zero, link.data_line};
            pin_sync_q <= pin_meta_q;
        end
    end

    logic s_supply, s_three, s_data, s_stray, clk_in, rise, fall;

    assign s_supply = pin_sync_q[PIN_SUPPLY];
    assign s_three = pin_sync_q[PIN_B3];
    assign s_data = pin_sync_q[PIN_DATA];
    assign s_stray = pin_sync_q[PIN_B1] | pin_sync_q[PIN_B0];
    // either upper button clocks
    assign clk_in = s_three | pin_sync_q[PIN_B2];
    assign rise = clk_in & ~clk_prev_q;
    assign fall = ~clk_in & clk_prev_q;

    // ==========================================================
    // sequencer and storage
    sepv_dev_state_e state_q, state_d;
    logic [TIMER_W-1:0] timer_q, timer_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [FRAME_BITS-1:0] shift_q, shift_d;
    logic [ADDR_W-1:0] word_q, word_d;
    logic ack_q, ack_d, dout_q, dout_d, doe_q, doe_d, cmp_err_q, cmp_err_d;
    logic [WORD_BITS-1:0] mem_q [NUM_WORDS], mem_d [NUM_WORDS];
    logic [WORD_BITS-1:0] rd_data_d;
    logic prog_mode_d, verify_mode_d, done_d;

    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        word_d = word_q;
        ack_d = ack_q;
        dout_d = dout_q;
        doe_d = doe_q;
        cmp_err_d = cmp_err_q;
        mem_d = mem_q;
        unique case (state_q)
            DEV_IDLE: begin
                doe_d = 1'b0;
                if (!s_three) begin
                    timer_d = '0;
                    if (timer_q >= TIMER_W'(HOLD_CYC)) begin
                        state_d = DEV_SETUP;
                    end
                end else if (timer_q < TIMER_W'(HOLD_CYC)) begin
                    timer_d = timer_q + 1'b1;
                end
            end
            DEV_SETUP: begin
                timer_d = timer_q + 1'b1;
                if (s_data) begin
                    state_d = DEV_SHIFT;
                    cnt_d = '0;
                    word_d = '0;
                    cmp_err_d = 1'b0;
                end else if (s_three || timer_q >= TIMER_W'(SETUP_CYC)) begin
                    // late data rise: no entry
                    state_d = DEV_IDLE;
                    timer_d = '0;
                end
            end
            DEV_SHIFT: begin
                if (rise) begin
                    shift_d = {s_data, shift_q[FRAME_BITS-1:1]};
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(FRAME_BITS - 1)) begin
                        state_d = DEV_WRITE;
                        timer_d = '0;
                        // high half must be ~word
                        ack_d = (shift_d[FRAME_BITS-1:WORD_BITS] == ~shift_d[WORD_BITS-1:0]);
                    end
                end
            end
            DEV_WRITE: begin
                timer_d = timer_q + 1'b1;
                if (timer_q >= TIMER_W'(WRITE_CYC - 1)) begin
                    if (ack_q) begin
                        if (word_q == '0) begin
                            for (int i = 0; i < NUM_WORDS; i++) begin
                                mem_d[i] = '0;
                            end
                        end
                        mem_d[word_q] = shift_q[WORD_BITS-1:0];
                        word_d = word_q + 1'b1;
                    end else begin
                        cmp_err_d = 1'b1;
                    end
                    state_d = DEV_ACK;
                    doe_d = 1'b1;
                    dout_d = ack_q;
                end
            end
            DEV_ACK: begin
                if (rise) begin
                    doe_d = 1'b0;
                    cnt_d = '0;
                    // verify only after all pairs
                    state_d = (word_q == ADDR_W'(NUM_WORDS)) ? DEV_VERIFY : DEV_SHIFT;
                end
            end
            DEV_VERIFY: begin
                if (rise && cnt_q < CNT_W'(IMAGE_BITS)) begin
                    doe_d = 1'b1;
                    dout_d = mem_q[cnt_q[CNT_W-1:4]][cnt_q[3:0]];
                    cnt_d = cnt_q + 1'b1;
                end else if (fall && cnt_q == CNT_W'(IMAGE_BITS)) begin
                    doe_d = 1'b0;
                    state_d = DEV_DONE;
                end
            end
            DEV_DONE: begin
                // stays silent until power is removed or a stray button aborts
                doe_d = 1'b0;
            end
            default: state_d = DEV_IDLE;
        endcase
        // power loss or stray button aborts
        if (!s_supply || (s_stray && state_q != DEV_IDLE)) begin
            state_d = DEV_IDLE;
            timer_d = '0;
            doe_d = 1'b0;
        end
    end

    always_comb begin
        rd_data_d = '0;
        if (rd_addr_i < ADDR_W'(NUM_WORDS)) begin
            rd_data_d = mem_q[rd_addr_i];
        end
        prog_mode_d = (state_d == DEV_SETUP) || (state_d == DEV_SHIFT) ||
                      (state_d == DEV_WRITE) || (state_d == DEV_ACK);
        verify_mode_d = (state_d == DEV_VERIFY);
        done_d = (state_d == DEV_DONE);
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_q <= DEV_IDLE;
            timer_q <= '0;
            cnt_q <= '0;
            shift_q <= '0;
            word_q <= '0;
            ack_q <= 1'b0;
            dout_q <= 1'b0;
            doe_q <= 1'b0;
            cmp_err_q <= 1'b0;
            clk_prev_q <= 1'b0;
            rd_data_o <= '0;
            prog_mode_o <= 1'b0;
            verify_mode_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            word_q <= word_d;
            ack_q <= ack_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
            cmp_err_q <= cmp_err_d;
            clk_prev_q <= clk_in;
            rd_data_o <= rd_data_d;
            prog_mode_o <= prog_mode_d;
            verify_mode_o <= verify_mode_d;
            done_o <= done_d;
        end
    end

    // nonvolatile: not reset
    always_ff @(posedge ref_clk_i) begin
        mem_q <= mem_d;
    end

    assign cmp_err_o = cmp_err_q;
    assign link.dev_data = dout_q;
    assign link.dev_data_oe = doe_q;

endmodule

`default_nettype wire

/* logic/sepv_programmer.sv */
// programmer end: entry sequence, word download with ack, verify, power-off
`timescale 1ns/10ps
`default_nettype none

module sepv_programmer
    import sepv_pkg::*;
#(
    parameter int HOLD_CYC = ENTRY_HOLD_CYC,
    parameter int LOW_CYC = CLK_LOW_CYC,
    parameter int HIGH_CYC = CLK_HIGH_CYC,
    parameter int WAIT_CYC = PRG_WAIT_CYC
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    sepv_if.prg link,
    input wire logic start_i,
    input wire logic [IMAGE_BITS-1:0] image_i,
    output logic busy_o,
    output logic done_o,
    output logic ack_fail_o,
    output logic verify_ok_o,
    output logic [IMAGE_BITS-1:0] readback_o
);

    // ==========================================================
    // data line synchroniser
    logic data_meta_q;
    logic s_data;

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            data_meta_q <= 1'b0;
            s_data <= 1'b0;
        end else begin
            data_meta_q <= link.data_line;
            s_data <= data_meta_q;
        end
    end

    // ==========================================================
    // sequencer
    sepv_prg_state_e state_q, state_d;
    logic [TIMER_W-1:0] timer_q, timer_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [ADDR_W-1:0] word_q, word_d;
    logic [IMAGE_BITS-1:0] img_q, img_d;
    logic [IMAGE_BITS-1:0] rb_d;
    logic supply_q, supply_d, clk_q, clk_d, dout_q, dout_d, doe_q, doe_d;
    logic ack_q, ack_d, busy_d, done_d, fail_d, ok_d;
    logic frame_bit;

    // low half is the word, high half its complement, bit 0 first
    always_comb begin
        frame_bit = img_q[{word_q, cnt_q[3:0]}] ^ cnt_q[4];
    end

    always_comb begin
        state_d = state_q;
        timer_d = timer_q + 1'b1;
        cnt_d = cnt_q;
        word_d = word_q;
        img_d = img_q;
        rb_d = readback_o;
        supply_d = supply_q;
        clk_d = clk_q;
        dout_d = dout_q;
        doe_d = doe_q;
        ack_d = ack_q;
        busy_d = busy_o;
        done_d = done_o;
        fail_d = ack_fail_o;
        ok_d = verify_ok_o;
        unique case (state_q)
            PRG_IDLE: begin
                timer_d = '0;
                if (start_i) begin
                    state_d = PRG_HOLD;
                    supply_d = 1'b1;
                    clk_d = 1'b1;
                    img_d = image_i;
                    word_d = '0;
                    cnt_d = '0;
                    busy_d = 1'b1;
                    done_d = 1'b0;
                    fail_d = 1'b0;
                    ok_d = 1'b0;
                end
            end
            PRG_HOLD: if (timer_q == TIMER_W'(HOLD_CYC - 1)) begin
                state_d = PRG_SETUP;
                timer_d = '0;
                clk_d = 1'b0;
                doe_d = 1'b1;
                dout_d = 1'b1;
            end
            PRG_SETUP: if (timer_q == TIMER_W'(LOW_CYC - 1)) begin
                state_d = PRG_BIT_LOW;
                timer_d = '0;
            end
            PRG_BIT_LOW: begin
                doe_d = 1'b1;
                dout_d = frame_bit;
                if (timer_q == TIMER_W'(LOW_CYC - 1)) begin
                    state_d = PRG_BIT_HIGH;
                    timer_d = '0;
                    clk_d = 1'b1;
                end
            end
            PRG_BIT_HIGH: if (timer_q == TIMER_W'(HIGH_CYC - 1)) begin
                timer_d = '0;
                clk_d = 1'b0;
                if (cnt_q == CNT_W'(FRAME_BITS - 1)) begin
                    state_d = PRG_WAIT;
                    cnt_d = '0;
                    doe_d = 1'b0;
                end else begin
                    state_d = PRG_BIT_LOW;
                    cnt_d = cnt_q + 1'b1;
                end
            end
            PRG_WAIT: if (timer_q == TIMER_W'(WAIT_CYC - 1)) begin
                state_d = PRG_ACK_HIGH;
                timer_d = '0;
                ack_d = s_data;
                clk_d = 1'b1;
            end
            PRG_ACK_HIGH: if (timer_q == TIMER_W'(HIGH_CYC - 1)) begin
                timer_d = '0;
                clk_d = 1'b0;
                if (!ack_q) begin
                    state_d = PRG_OFF;
                    fail_d = 1'b1;
                end else if (word_q == ADDR_W'(NUM_WORDS - 1)) begin
                    state_d = PRG_VER_LOW;
                end else begin
                    state_d = PRG_BIT_LOW;
                    word_d = word_q + 1'b1;
                end
            end
            PRG_VER_LOW: if (timer_q == TIMER_W'(LOW_CYC - 1)) begin
                state_d = PRG_VER_HIGH;
                timer_d = '0;
                clk_d = 1'b1;
            end
            PRG_VER_HIGH: if (timer_q == TIMER_W'(HIGH_CYC - 1)) begin
                timer_d = '0;
                clk_d = 1'b0;
                rb_d[cnt_q] = s_data;
                cnt_d = cnt_q + 1'b1;
                state_d = (cnt_q == CNT_W'(IMAGE_BITS - 1)) ? PRG_OFF : PRG_VER_LOW;
            end
            PRG_OFF: if (timer_q == TIMER_W'(LOW_CYC - 1)) begin
                // power must drop after every program/verify cycle
                state_d = PRG_IDLE;
                timer_d = '0;
                supply_d = 1'b0;
                doe_d = 1'b0;
                busy_d = 1'b0;
                done_d = 1'b1;
                ok_d = !ack_fail_o && (readback_o == img_q);
            end
            default: state_d = PRG_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_q <= PRG_IDLE;
            timer_q <= '0;
            cnt_q <= '0;
            word_q <= '0;
            img_q <= '0;
            readback_o <= '0;
            supply_q <= 1'b0;
            clk_q <= 1'b0;
            dout_q <= 1'b0;
            doe_q <= 1'b0;
            ack_q <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            ack_fail_o <= 1'b0;
            verify_ok_o <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            cnt_q <= cnt_d;
            word_q <= word_d;
            img_q <= img_d;
            readback_o <= rb_d;
            supply_q <= supply_d;
            clk_q <= clk_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
            ack_q <= ack_d;
            busy_o <= busy_d;
            done_o <= done_d;
            ack_fail_o <= fail_d;
            verify_ok_o <= ok_d;
        end
    end

    assign link.supply_on = supply_q;
    assign link.button_input_three = clk_q;
    assign link.button_input_two = 1'b0;
    assign link.button_input_one = 1'b0;
    assign link.button_input_zero = 1'b0;
    assign link.prg_data = dout_q;
    assign link.prg_data_oe = doe_q;

endmodule

`default_nettype wire

/* tb/sepv_link_props.sv */
// assertion checker for the program/verify link between the two ends
`timescale 1ns/10ps
`default_nettype none

module sepv_link_props #(
    parameter int HOLD_CYC = 40,
    parameter int WRITE_CYC = 50
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic supply_on,
    input wire logic button_input_three,
    input wire logic button_input_two,
    input wire logic button_input_one,
    input wire logic button_input_zero,
    input wire logic prg_data,
    input wire logic prg_data_oe,
    input wire logic dev_data,
    input wire logic dev_data_oe,
    input wire logic data_line
);
    // ==========================================================
    // link phase tracking
    logic three_q, oe_q, in_q, in_d, wt_q, wt_d, rise;
    logic [15:0] hi_q, hi_d, wc_q, wc_d;
    logic [3:0] ack_q, ack_d;
    logic [7:0] ver_q, ver_d;

    always_comb begin
        rise = button_input_three && !three_q;
        hi_d = button_input_three ? hi_q + 16'h1 : 16'h0;
        in_d = in_q || (three_q && !button_input_three);
        // programmer release opens a write wait
        wt_d = (oe_q && !prg_data_oe) || (wt_q && !rise);
        wc_d = wt_q ? wc_q + 16'h1 : 16'h0;
        ack_d = ack_q + {3'h0, rise && wt_q};
        ver_d = ver_q + {7'h0, rise && ack_q == 4'hC};
        if (sys_rst_i || !supply_on) begin
            in_d = 1'b0;
            wt_d = 1'b0;
            ack_d = 4'h0;
            ver_d = 8'h0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        three_q <= button_input_three;
        oe_q <= prg_data_oe;
        in_q <= in_d;
        wt_q <= wt_d;
        hi_q <= hi_d;
        wc_q <= wc_d;
        ack_q <= ack_d;
        ver_q <= ver_d;
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_entry_fall;
        $fell(button_input_three) && !in_q && supply_on;
    endsequence
    sequence s_ack_clock;
        rise && wt_q;
    endsequence
    sequence s_ver_clock;
        rise && ack_q == 4'hC && supply_on;
    endsequence

    property p_no_clash;
        !(prg_data_oe && dev_data_oe);
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("data line clash");
    property p_hold_len;
        s_entry_fall |-> hi_q >= 16'(HOLD_CYC);
    endproperty
    a_hold_len: assert property (p_hold_len)
        else $error("entry hold too short");
    property p_entry_mark;
        s_entry_fall |-> ##[0:2] (prg_data_oe && prg_data);
    endproperty
    a_entry_mark: assert property (p_entry_mark)
        else $error("no entry data rise");
    property p_buttons_low;
        supply_on |-> !button_input_one && !button_input_zero && !button_input_two;
    endproperty
    a_buttons_low: assert property (p_buttons_low)
        else $error("unused button high");
    property p_data_hold;
        button_input_three && $past(button_input_three) && prg_data_oe |-> $stable(prg_data);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data moved during clock high");
    property p_write_wait;
        s_ack_clock |-> wc_q >= 16'(WRITE_CYC);
    endproperty
    a_write_wait: assert property (p_write_wait)
        else $error("ack clock too early");
    property p_ack_high;
        s_ack_clock |-> dev_data_oe && data_line;
    endproperty
    a_ack_high: assert property (p_ack_high)
        else $error("no ack after good word");
    property p_ack_release;
        s_ack_clock |-> ##[1:5] !dev_data_oe || ack_q == 4'hB;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("ack not released");
    property p_ver_drive;
        s_ver_clock |-> ##[1:4] dev_data_oe;
    endproperty
    a_ver_drive: assert property (p_ver_drive)
        else $error("verify bit not driven");
    property p_ver_end;
        ver_q == 8'd192 && $fell(button_input_three) |-> ##[1:5] !dev_data_oe;
    endproperty
    a_ver_end: assert property (p_ver_end)
        else $error("drive after last verify bit");
    property p_quiet;
        dev_data_oe |-> wt_q || $past(wt_q, 5) || ack_q == 4'hC;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("stray device drive");
    property p_off_quiet;
        !supply_on [*4] |-> !dev_data_oe;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("drive while unpowered");
endmodule

`default_nettype wire

/* tb/serial_eeprom_program_verify_tb.sv */
// bench: programmer against device, plus a bench-driven link
`timescale 1ns/10ps
`default_nettype none

module serial_eeprom_program_verify_tb;
    import sepv_pkg::*;
    localparam int HOLD = 40;
    localparam int WRC = 50;
    localparam logic [IMAGE_BITS-1:0] IMG_A =
        192'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210_5A5A_C3C3_0F0F_F00F;
    logic ref_clk, sys_rst, start, busy, p_done, ack_fail, ver_ok, pm, vm, d_done, cerr;
    logic pm2, vm2, done2, cerr2, ack;
    logic [IMAGE_BITS-1:0] image, readback;
    logic [ADDR_W-1:0] rd_addr;
    logic [WORD_BITS-1:0] rd_data, rd_data2;
    int fails = 0;
    int checked = 0;
    int cycles = 0;

    sepv_if if1();
    sepv_if if2();
    sepv_device #(.HOLD_CYC(HOLD), .SETUP_CYC(40), .WRITE_CYC(WRC)) i_sepv_device (
        .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .link(if1.dev), .rd_addr_i(rd_addr),
        .rd_data_o(rd_data), .prog_mode_o(pm), .verify_mode_o(vm), .done_o(d_done), .cmp_err_o(cerr));
    sepv_device #(.HOLD_CYC(HOLD), .SETUP_CYC(40), .WRITE_CYC(WRC)) i_sepv_device_2 (
        .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .link(if2.dev), .rd_addr_i(rd_addr),
        .rd_data_o(rd_data2), .prog_mode_o(pm2), .verify_mode_o(vm2), .done_o(done2),
        .cmp_err_o(cerr2));
    sepv_programmer #(.HOLD_CYC(HOLD), .LOW_CYC(10), .HIGH_CYC(10), .WAIT_CYC(66)) i_sepv_programmer (
        .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .link(if1.prg), .start_i(start), .image_i(image),
        .busy_o(busy), .done_o(p_done), .ack_fail_o(ack_fail), .verify_ok_o(ver_ok),
        .readback_o(readback));
    sepv_link_props #(.HOLD_CYC(HOLD), .WRITE_CYC(WRC)) i_sepv_link_props (
        .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .supply_on(if1.supply_on),
        .button_input_three(if1.button_input_three), .button_input_two(if1.button_input_two),
        .button_input_one(if1.button_input_one), .button_input_zero(if1.button_input_zero),
        .prg_data(if1.prg_data), .prg_data_oe(if1.prg_data_oe), .dev_data(if1.dev_data),
        .dev_data_oe(if1.dev_data_oe), .data_line(if1.data_line));

    // ==========================================================
    // helpers
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input logic [IMAGE_BITS-1:0] got, input logic [IMAGE_BITS-1:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            $display("wrong value at %0t: run timed out", $time);
            close_out();
        end
    end

    task automatic rd_chk(input int a, input logic [WORD_BITS-1:0] exp, input logic two);
        rd_addr = ADDR_W'(a);
        tick(1);
        chk(IMAGE_BITS'(two ? rd_data2 : rd_data), IMAGE_BITS'(exp), "stored word");
    endtask

    task automatic run_prog(input logic [IMAGE_BITS-1:0] img);
        int n;
        image = img;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        n = 0;
        while (p_done !== 1'b1 && n < 30000) begin
            tick(1);
            n++;
        end
        chk(IMAGE_BITS'({p_done, ver_ok, ack_fail, busy, d_done, cerr, pm, vm}),
            IMAGE_BITS'(8'hC8), "programmer status");
        chk(readback, img, "verify read-back");
        for (int k = 0; k < NUM_WORDS; k++) rd_chk(k, img[16*k +: 16], 1'b0);
        rd_chk(12, 16'h0000, 1'b0);
    endtask

    // ==========================================================
    // second link: bench as programmer
    task automatic lk(input logic b);
        if2.prg_data = b;
        #62.5 if2.button_input_three = 1'b1;
        #62.5 if2.button_input_three = 1'b0;
    endtask

    task automatic entry2(input int gap);
        if2.prg_data = 1'b0;
        if2.button_input_three = 1'b1;
        #((HOLD + 10) * 4);
        if2.button_input_three = 1'b0;
        #(gap * 4);
        if2.prg_data = 1'b1;
        if2.prg_data_oe = 1'b1;
        #62.5;
    endtask

    task automatic frame2(input logic [15:0] w, input logic [15:0] c, output logic a);
        for (int i = 0; i < 16; i++) lk(w[i]);
        for (int i = 0; i < 16; i++) lk(c[i]);
        // release the line for the ack
        if2.prg_data_oe = 1'b0;
        #((WRC + 20) * 4);
        a = if2.data_line;
        lk(1'b0);
        if2.prg_data_oe = 1'b1;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        start = 1'b0;
        image = '0;
        rd_addr = '0;
        if2.supply_on = 1'b0;
        if2.button_input_three = 1'b0;
        if2.button_input_two = 1'b0;
        if2.button_input_one = 1'b0;
        if2.button_input_zero = 1'b0;
        if2.prg_data = 1'b0;
        if2.prg_data_oe = 1'b0;
        sys_rst = 1'b1;
        tick(4);
        sys_rst = 1'b0;
        run_prog(IMG_A);
        $display("test program_a finished");
        run_prog(~IMG_A);
        $display("test reprogram finished");
        tick(1);
        // keep link edges off clock edges
        #0.25;
        if2.supply_on = 1'b1;
        for (int i = 0; i < 8; i++) begin
            lk(1'b0);
            chk(IMAGE_BITS'(if2.dev_data_oe | vm2), '0, "read-back unprogrammed");
        end
        entry2(70);
        #40;
        chk(IMAGE_BITS'(pm2), '0, "late data rise");
        entry2(2);
        frame2(16'h1234, 16'h1234, ack);
        chk(IMAGE_BITS'({ack, cerr2}), IMAGE_BITS'(1), "bad complement");
        frame2(16'hBEEF, 16'h4110, ack);
        chk(IMAGE_BITS'({ack, pm2}), IMAGE_BITS'(3), "good word");
        if2.button_input_one = 1'b1;
        #40;
        chk(IMAGE_BITS'(pm2), '0, "stray button abort");
        if2.button_input_one = 1'b0;
        if2.supply_on = 1'b0;
        rd_chk(0, 16'hBEEF, 1'b1);
        rd_chk(1, 16'h0000, 1'b1);
        $display("test second_link finished");
        close_out();
    end
endmodule

`default_nettype wire
